// file: design/mode_twohand_logic.sv
// mode selector switch and two-hand control combiner with apb registers
module mode_twohand_logic
  import mode_twohand_pkg::*;
#(
  parameter int unsigned SAMPLE_CYC = SAMPLE_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        mode_input_a,
  input  wire logic        mode_input_b,
  input  wire logic        mode_input_c,
  input  wire logic        twohand_left_a,
  input  wire logic        twohand_left_b,
  input  wire logic        twohand_right_a,
  input  wire logic        twohand_right_b,
  output logic             safe_mode_a,
  output logic             safe_mode_b,
  output logic             safe_mode_c,
  output logic             twohand_combined_out,
  output logic             input_error,
  output logic      [15:0] input_error_code,
  output logic             irq
);

  localparam int unsigned PIN_W = 7;

  logic [PIN_W-1:0]  sync1_q;
  logic [PIN_W-1:0]  sync2_q;
  logic [PIN_W-1:0]  line_q [TAPS];
  logic [PIN_W-1:0]  tap;
  logic [31:0]       div_q;
  logic              tick;
  logic [CTRL_W-1:0] ctrl_q;
  logic [15:0]       sel_disc_q;
  logic [15:0]       th_disc_q;
  logic [15:0]       chan_disc_q;
  logic [ST_W-1:0]   status_q;
  logic [ST_W-1:0]   mask_q;
  logic [ST_W-1:0]   err_q;
  logic [ST_W-1:0]   err_d;
  logic [ST_W-1:0]   event_set;
  logic [2:0]        safe_q;
  logic              sel_valid_q;
  logic              th_out_q;
  logic [CNT_W-1:0]  sel_cnt_q;
  logic [CNT_W-1:0]  th_cnt_q;
  logic [CNT_W-1:0]  chan_cnt_q [2];
  logic [CNT_W-1:0]  sel_thr;
  logic [CNT_W-1:0]  th_thr;
  logic [CNT_W-1:0]  chan_thr;
  logic [2:0]        logic_mode;
  logic              logic_twohand_left;
  logic              logic_twohand_right;
  logic [1:0]        chan_bad;
  logic              sel_en;
  logic              th_en;
  logic              one_hot;
  logic              wr_en;
  logic              rd_setup;
  logic [ST_W-1:0]   w1c;

  // two-flop synchronisers for all operator pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {twohand_right_b, twohand_right_a, twohand_left_b, twohand_left_a,
                  mode_input_c, mode_input_b, mode_input_a};
      sync2_q <= sync1_q;
    end
  end

  // sample tick divider, one pulse per sample period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= '0;
    end else if (div_q == SAMPLE_CYC - 1) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 32'h1;
    end
  end
  assign tick = (div_q == SAMPLE_CYC - 1);

  // delay line of one evaluation cycle, oldest tap feeds the logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < TAPS; i++) begin
        line_q[i] <= '0;
      end
    end else if (tick) begin // see RQ6 see RQ15 see RQ19
      line_q[0] <= sync2_q;
      for (int i = 1; i < TAPS; i++) begin
        line_q[i] <= line_q[i-1];
      end
    end
  end
  assign tap = line_q[TAPS-1];

  // thresholds: discrepancy settings are in evaluation cycles
  assign sel_thr  = CNT_W'(sel_disc_q) * CNT_W'(TAPS);  // see RQ9
  assign th_thr   = CNT_W'(th_disc_q) * CNT_W'(TAPS);
  assign chan_thr = CNT_W'(chan_disc_q) * CNT_W'(TAPS);

  // enables and decoded logical inputs
  assign sel_en     = ctrl_q[CTRL_SEL_ACT];  // see RQ8
  assign th_en      = ctrl_q[CTRL_TH_ACT] & ctrl_q[CTRL_TYPE_L]
                      & ctrl_q[CTRL_TYPE_R];  // see RQ12 see RQ18
  assign logic_mode = tap[2:0];
  assign one_hot    = (logic_mode == 3'h1) || (logic_mode == 3'h2)
                      || (logic_mode == 3'h4);  // see RQ2

  // per-input channel check, equivalent or antivalent pair
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_chan
      logic chan_b;
      assign chan_b      = tap[4+2*g] ^ ctrl_q[CTRL_ANTI_L+g];
      assign chan_bad[g] = (tap[3+2*g] != chan_b);  // see RQ13
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          chan_cnt_q[g] <= '0;
        end else if (tick) begin
          if (!chan_bad[g]) begin
            chan_cnt_q[g] <= '0;
          end else if (chan_cnt_q[g] != chan_thr) begin
            chan_cnt_q[g] <= chan_cnt_q[g] + CNT_W'(1);
          end
        end
      end
    end
  endgenerate
  assign logic_twohand_left  = tap[3] & ~chan_bad[0];
  assign logic_twohand_right = tap[5] & ~chan_bad[1];

  // selector: copy, default or hold last valid state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      safe_q      <= SAFE_START;  // see RQ3
      sel_valid_q <= 1'b0;
      sel_cnt_q   <= '0;
    end else if (tick) begin
      if (!sel_en) begin
        safe_q      <= SAFE_START;  // see RQ3
        sel_valid_q <= 1'b0;
        sel_cnt_q   <= '0;
      end else if (one_hot) begin
        safe_q      <= logic_mode;  // see RQ1
        sel_valid_q <= 1'b1;
        sel_cnt_q   <= '0;
      end else begin
        if (sel_cnt_q != sel_thr) begin  // safe_q holds, see RQ5
          sel_cnt_q <= sel_cnt_q + CNT_W'(1);
        end else begin
          sel_valid_q <= 1'b0;  // see RQ4
        end
      end
    end
  end

  // two-hand combiner and its discrepancy timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      th_out_q <= 1'b0;
      th_cnt_q <= '0;
    end else if (tick) begin
      th_out_q <= th_en & (logic_twohand_left | logic_twohand_right);  // see RQ11
      if (!th_en || (logic_twohand_left == logic_twohand_right)) begin
        th_cnt_q <= '0;
      end else if (th_cnt_q != th_thr) begin
        th_cnt_q <= th_cnt_q + CNT_W'(1);
      end
    end
  end

  // live error flags, raised when a timer has reached its threshold
  always_comb begin
    err_d = err_q;
    if (tick) begin
      err_d[ST_SEL_ERR] = sel_en && !one_hot && (sel_cnt_q == sel_thr);  // see RQ4 see RQ7
      err_d[ST_TH_ERR]  = th_en && (logic_twohand_left != logic_twohand_right)
                          && (th_cnt_q == th_thr);  // see RQ14 see RQ16
      err_d[ST_CHAN_L]  = th_en && chan_bad[0] && (chan_cnt_q[0] == chan_thr);
      err_d[ST_CHAN_R]  = th_en && chan_bad[1] && (chan_cnt_q[1] == chan_thr);
    end
  end
  assign event_set = err_d & ~err_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_q <= '0;
    end else begin
      err_q <= err_d;
    end
  end

  // apb decode
  assign wr_en    = psel & penable & pwrite;
  assign rd_setup = psel & ~penable;
  assign w1c      = (wr_en && paddr == STATUS_OFF) ? pwdata[ST_W-1:0] : '0;

  // configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q      <= CTRL_RST;
      sel_disc_q  <= DISC_RST;
      th_disc_q   <= DISC_RST;
      chan_disc_q <= DISC_RST;
      mask_q      <= '0;
    end else if (wr_en) begin
      if (paddr == CTRL_OFF) begin
        ctrl_q <= pwdata[CTRL_W-1:0];
      end else if (paddr == SEL_DISC_OFF) begin
        sel_disc_q <= pwdata[15:0];
      end else if (paddr == TH_DISC_OFF) begin
        th_disc_q <= pwdata[15:0];  // see RQ17
      end else if (paddr == CHAN_DISC_OFF) begin
        chan_disc_q <= pwdata[15:0];
      end else if (paddr == MASK_OFF) begin
        mask_q <= pwdata[ST_W-1:0];
      end
    end
  end

  // sticky status, a new event wins over a write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~w1c) | event_set;
    end
  end

  // read data and error captured in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (rd_setup) begin
      pslverr <= 1'b0;
      prdata  <= '0;
      if (paddr == CTRL_OFF) begin
        prdata <= 32'(ctrl_q);
      end else if (paddr == SEL_DISC_OFF) begin
        prdata <= 32'(sel_disc_q);
      end else if (paddr == TH_DISC_OFF) begin
        prdata <= 32'(th_disc_q);
      end else if (paddr == CHAN_DISC_OFF) begin
        prdata <= 32'(chan_disc_q);
      end else if (paddr == STATUS_OFF) begin
        prdata <= 32'(status_q);
      end else if (paddr == MASK_OFF) begin
        prdata <= 32'(mask_q);
      end else if (paddr == STATE_OFF) begin
        prdata <= {20'h0, err_q, logic_mode, sel_valid_q, th_out_q, safe_q};
      end else begin
        pslverr <= 1'b1;
      end
    end
  end

  // outputs
  assign pready               = 1'b1;
  assign safe_mode_a          = safe_q[0];
  assign safe_mode_b          = safe_q[1];
  assign safe_mode_c          = safe_q[2];
  assign twohand_combined_out = th_out_q;
  assign input_error          = |err_q;  // see RQ10
  assign input_error_code     = input_error ? ERR_CODE : 16'h0000;  // see RQ10
  assign irq                  = |(status_q & mask_q);

  // assertions
  a_sel_default: assert property (@(posedge pclk) disable iff (!presetn)
    tick && !sel_en |=> safe_q == SAFE_START) // see RQ3
    else $error("safe outputs not at start state while selector off");
  a_sel_copy: assert property (@(posedge pclk) disable iff (!presetn)
    tick && sel_en && one_hot |=> safe_q == $past(logic_mode)) // see RQ1
    else $error("valid selector state not copied");
  a_sel_hold: assert property (@(posedge pclk) disable iff (!presetn)
    tick && sel_en && !one_hot |=> $stable(safe_q)) // see RQ5
    else $error("safe outputs moved during selector fault");
  a_sel_error: assert property (@(posedge pclk) disable iff (!presetn)
    tick && sel_en && !one_hot && sel_cnt_q == sel_thr
    |=> err_q[ST_SEL_ERR] && !sel_valid_q && input_error) // see RQ4
    else $error("selector error not raised at threshold");
  a_sel_early: assert property (@(posedge pclk) disable iff (!presetn)
    tick && sel_cnt_q != sel_thr |=> !err_q[ST_SEL_ERR]) // see RQ7
    else $error("selector error before discrepancy time");
  a_th_or_out: assert property (@(posedge pclk) disable iff (!presetn)
    tick |=> th_out_q == $past(th_en & (logic_twohand_left | logic_twohand_right)))
    else $error("two-hand output not the or of inputs"); // see RQ11
  a_th_gate: assert property (@(posedge pclk) disable iff (!presetn)
    tick && !(ctrl_q[CTRL_TYPE_L] && ctrl_q[CTRL_TYPE_R]) |=> !th_out_q) // see RQ12
    else $error("two-hand active without two-hand sensor type");
  a_th_error: assert property (@(posedge pclk) disable iff (!presetn)
    tick && th_en && logic_twohand_left != logic_twohand_right && th_cnt_q == th_thr
    && !err_q[ST_TH_ERR] |=> err_q[ST_TH_ERR] && status_q[ST_TH_ERR]) // see RQ14
    else $error("two-hand error not raised at threshold");
  a_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
    event_set[ST_SEL_ERR] && w1c[ST_SEL_ERR] |=> status_q[ST_SEL_ERR])
    else $error("event lost under status clear");
  a_line_delay: assert property (@(posedge pclk) disable iff (!presetn)
    tick |=> line_q[1] == $past(line_q[0])) // see RQ6
    else $error("delay line did not shift");
  a_code_value: assert property (@(posedge pclk) disable iff (!presetn)
    err_q[ST_TH_ERR] |-> input_error && input_error_code == ERR_CODE) // see RQ10
    else $error("error code wrong while two-hand fault");
  a_th_early: assert property (@(posedge pclk) disable iff (!presetn)
    tick && th_cnt_q != th_thr |=> !err_q[ST_TH_ERR]) // see RQ16
    else $error("two-hand error before discrepancy time");
  a_sel_recover: assert property (@(posedge pclk) disable iff (!presetn)
    tick && sel_en && one_hot |=> !err_q[ST_SEL_ERR] && sel_valid_q) // see RQ4
    else $error("selector not valid again after good input");
  a_chan_left: assert property (@(posedge pclk) disable iff (!presetn)
    tick && th_en && chan_bad[0] && chan_cnt_q[0] == chan_thr |=> err_q[ST_CHAN_L]) // see RQ13
    else $error("left channel error not raised at threshold");
  a_chan_right: assert property (@(posedge pclk) disable iff (!presetn)
    tick && th_en && chan_bad[1] && chan_cnt_q[1] == chan_thr |=> err_q[ST_CHAN_R]) // see RQ13
    else $error("right channel error not raised at threshold");
  a_status_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    status_q[ST_TH_ERR] && !w1c[ST_TH_ERR] |=> status_q[ST_TH_ERR]) // see RQ14
    else $error("two-hand status bit lost without clear");

  c_sel_error: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(err_q[ST_SEL_ERR]));
  c_th_error: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(err_q[ST_TH_ERR]));
  c_th_press: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(th_out_q));
  c_mode_b: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(safe_q[1]));
  c_chan_error: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(err_q[ST_CHAN_L]));

endmodule // mode_twohand_logic

// file: include/mode_twohand_pkg.sv
// constants, register map and field layout of the mode selector and two-hand logic
//
// Summary of operation
// RQ1: normal operation copies each mode input onto its safe mode output.
// RQ2: selector mode requires exactly one mode input high, with discrepancy timing.
// RQ3: at start or with selector analysis off, outputs are a=1, b=0, c=0.
// RQ4: no or several inputs high beyond discrepancy time raises error, marks inputs invalid.
// RQ5: while inputs are faulty, safe outputs hold the last error-free state.
// RQ6: mode input change reaches safe output after 2.0 to 2.1 ms.
// RQ7: one-of-three violation errors within 2.0 to 2.1 ms plus discrepancy time.
// RQ8: selector activation enables one-of-three use; cleared means monitoring inactive.
// RQ9: selector discrepancy time bounds how long none or several inputs may be high.
// RQ10: selector and two-hand faults drive the internal input error with code 57-1.
// RQ11: two-hand output is the OR of both two-hand inputs.
// RQ12: two-hand mode activates only when both inputs have two-hand sensor type.
// RQ13: each two-hand input keeps its own channel equivalence or antivalence check.
// RQ14: two-hand inputs differing beyond two-hand discrepancy time raise an error.
// RQ15: two-hand input change reaches combined output after 2.0 to 2.1 ms.
// RQ16: two-hand violation errors within 2.0 to 2.1 ms plus discrepancy time.
// RQ17: software should set two-hand discrepancy longer than per-input discrepancy.
// RQ18: two-hand activation enables combined output and its discrepancy monitoring.
// RQ19: inputs, outputs and timers advance on a fixed evaluation cycle near 2 ms.
package mode_twohand_pkg;
  // timing
  localparam int unsigned CLK_PERIOD_NS    = 10;
  localparam int unsigned SAMPLE_PERIOD_NS = 100000;
  localparam int unsigned EVAL_PERIOD_NS   = 2000000;
  localparam int unsigned SAMPLE_CYCLES    = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned TAPS             = EVAL_PERIOD_NS / SAMPLE_PERIOD_NS;
  // register byte offsets
  localparam logic [7:0] CTRL_OFF      = 8'h00;
  localparam logic [7:0] SEL_DISC_OFF  = 8'h04;
  localparam logic [7:0] TH_DISC_OFF   = 8'h08;
  localparam logic [7:0] CHAN_DISC_OFF = 8'h0c;
  localparam logic [7:0] STATUS_OFF    = 8'h10;
  localparam logic [7:0] MASK_OFF      = 8'h14;
  localparam logic [7:0] STATE_OFF     = 8'h18;
  // control fields
  localparam int unsigned CTRL_SEL_ACT  = 0;
  localparam int unsigned CTRL_TH_ACT   = 1;
  localparam int unsigned CTRL_TYPE_L   = 2;
  localparam int unsigned CTRL_TYPE_R   = 3;
  localparam int unsigned CTRL_ANTI_L   = 4;
  localparam int unsigned CTRL_ANTI_R   = 5;
  localparam int unsigned CTRL_W        = 6;
  // status and mask fields
  localparam int unsigned ST_SEL_ERR    = 0;
  localparam int unsigned ST_TH_ERR     = 1;
  localparam int unsigned ST_CHAN_L     = 2;
  localparam int unsigned ST_CHAN_R     = 3;
  localparam int unsigned ST_W          = 4;
  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RST  = 6'h00;
  localparam logic [15:0]       DISC_RST  = 16'h0005;
  localparam logic [2:0]        SAFE_START = 3'h1;
  // internal input error code 57-1
  localparam logic [15:0]       ERR_CODE  = 16'h3901;
  localparam int unsigned       CNT_W     = 21;
endpackage

// file: tb/operator_panel.sv
// operator mode switch and two-hand pushbuttons driving the selector and two-hand pins
module operator_panel (
  input  wire logic [2:0] pos,
  input  wire logic       press_l,
  input  wire logic       press_r,
  output logic            mode_input_a,
  output logic            mode_input_b,
  output logic            mode_input_c,
  output logic            twohand_left_a,
  output logic            twohand_left_b,
  output logic            twohand_right_a,
  output logic            twohand_right_b
);
  timeunit 1ns;
  timeprecision 1ps;
  // switch contacts; several or none closed only when the bench asks for it
  assign mode_input_a = pos[0];
  assign mode_input_b = pos[1];
  assign mode_input_c = pos[2];
  // each button closes both of its channels together (equivalent wiring)
  assign twohand_left_a  = press_l;
  assign twohand_left_b  = press_l;
  assign twohand_right_a = press_r;
  assign twohand_right_b = press_r;
endmodule // operator_panel

// file: tb/tb_safe_mode_select_two_hand_logic.sv
// self-checking bench for the mode selector and two-hand logic
module tb_safe_mode_select_two_hand_logic;
  import mode_twohand_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, input_error;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] input_error_code;
  logic [2:0]  pos;
  logic        press_l, press_r, ma, mb, mc, la, lb, ra, rb, sa, sb, sc, tho, e;
  int          bad_count, checks, cyc;
  // design with a short sample period: evaluation cycle is 200 clocks
  mode_twohand_logic #(.SAMPLE_CYC(10)) mode_twohand_logic_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mode_input_a(ma), .mode_input_b(mb), .mode_input_c(mc),
    .twohand_left_a(la), .twohand_left_b(lb), .twohand_right_a(ra), .twohand_right_b(rb),
    .safe_mode_a(sa), .safe_mode_b(sb), .safe_mode_c(sc), .twohand_combined_out(tho),
    .input_error(input_error), .input_error_code(input_error_code), .irq(irq));
  operator_panel operator_panel_inst (
    .pos(pos), .press_l(press_l), .press_r(press_r), .mode_input_a(ma), .mode_input_b(mb),
    .mode_input_c(mc), .twohand_left_a(la), .twohand_left_b(lb), .twohand_right_a(ra),
    .twohand_right_b(rb));
  // clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      stop_test();
    end
  end
  task automatic stop_test();
    if (bad_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic outs(input string nm, input logic [3:0] exp);
    chk(nm, {28'h0, sa, sb, sc, tho}, {28'h0, exp});
  endtask
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; pos = 3'h1; press_l = 1'b0; press_r = 1'b0;
    wt(3);
    presetn <= 1'b1;
    outs("start", 4'h8);
    chk("err", {31'h0, input_error}, 32'h0);
    apb(1'b0, CTRL_OFF, 32'h0);
    chk("ctrl rst", rd, 32'h0);
    apb(1'b0, SEL_DISC_OFF, 32'h0);
    chk("disc rst", rd, {16'h0, DISC_RST});
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", {31'h0, e}, 32'h1);
    // selector off: pins ignored
    pos <= 3'h2;
    wt(250);
    outs("sel off", 4'h8);
    // selector on, follow the switch with evaluation delay
    apb(1'b1, SEL_DISC_OFF, 32'h1);
    apb(1'b1, MASK_OFF, 32'h1);
    apb(1'b1, CTRL_OFF, 32'h1);
    wt(250);
    outs("sel b", 4'h4);
    pos <= 3'h1;
    wt(199);
    outs("not yet", 4'h4);
    wt(16);
    outs("sel a", 4'h8);
    // two positions closed: error after delay plus discrepancy time
    pos <= 3'h3;
    wt(399);
    chk("early err", {31'h0, input_error}, 32'h0);
    wt(31);
    chk("sel err", {31'h0, input_error}, 32'h1);
    chk("code", {16'h0, input_error_code}, {16'h0, ERR_CODE});
    outs("hold", 4'h8);
    chk("irq", {31'h0, irq}, 32'h1);
    apb(1'b0, STATE_OFF, 32'h0);
    chk("valid", {31'h0, rd[4]}, 32'h0);
    // fault gone: the sticky bit outlives the live flag until written one
    pos <= 3'h4;
    wt(230);
    outs("sel c", 4'h2);
    apb(1'b0, STATUS_OFF, 32'h0);
    chk("sticky", rd, 32'h1);
    apb(1'b1, STATUS_OFF, 32'h1);
    wt(2);
    chk("irq clr", {31'h0, irq}, 32'h0);
    // two-hand with one type bit missing stays off
    apb(1'b1, CTRL_OFF, 32'h7);
    press_l <= 1'b1;
    wt(250);
    outs("th off", 4'h2);
    // two-hand window longer than the per-input window
    apb(1'b1, CHAN_DISC_OFF, 32'h1);
    apb(1'b1, TH_DISC_OFF, 32'h2);
    apb(1'b1, CTRL_OFF, 32'hf);
    wt(215);
    outs("th or", 4'h3);
    press_l <= 1'b0;
    wt(250);
    outs("th idle", 4'h2);
    // the lone left press outlived the window; check and clear that error
    apb(1'b0, STATUS_OFF, 32'h0);
    chk("th lone", rd, 32'h2);
    apb(1'b1, STATUS_OFF, 32'hf);
    press_r <= 1'b1;
    wt(199);
    outs("th wait", 4'h2);
    wt(16);
    outs("th r", 4'h3);
    wt(384);
    chk("th early", {31'h0, input_error}, 32'h0);
    wt(23);
    chk("th err", {31'h0, input_error}, 32'h1);
    apb(1'b0, STATUS_OFF, 32'h0);
    chk("th stat", rd, 32'h2);
    // left pair set antivalent while wired equivalent: channel error
    apb(1'b1, CTRL_OFF, 32'h1f);
    wt(220);
    apb(1'b0, STATUS_OFF, 32'h0);
    chk("chan err", rd, 32'h6);
    stop_test();
  end
endmodule // tb_safe_mode_select_two_hand_logic
